// ### rtl/tof_pkg.sv
package tof_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 100;

  // Times in ns and derived cycle counts
  localparam int T_BOOT_NS = 1_200_000;
  localparam int BOOT_CYCLES = T_BOOT_NS / CLK_PERIOD_NS;
  localparam int T_BUDGET_NS = 33_000_000;
  localparam int MEAS_CYCLES = T_BUDGET_NS / CLK_PERIOD_NS;
  localparam int T_MS_NS = 1_000_000;
  localparam int MS_CYCLES = T_MS_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // Bus address byte for a master write
  localparam logic [7:0] ADDR_WRITE = 8'h52;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // Write indices carried by the link
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_MODE = 8'h01;
  localparam logic [7:0] IDX_IRQ_EN = 8'h02;
  localparam logic [7:0] IDX_SPAD_BIAS = 8'h03;
  localparam logic [7:0] IDX_PHASE_CAL = 8'h04;
  localparam logic [7:0] IDX_INTER_MEAS = 8'h05;

  // Control byte fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_IRQ_CLR_BIT = 2;

  // Reset values
  localparam logic [7:0] SPAD_BIAS_RST = 8'h00;
  localparam logic [7:0] PHASE_CAL_RST = 8'h00;
  localparam logic [7:0] INTER_MEAS_RST = 8'h00;
  localparam logic IRQ_EN_RST = 1'b0;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_CONT = 2'h1,
    MODE_TIMED = 2'h2
  } range_mode_e;

  typedef enum logic [4:0] {
    ST_HW_STBY = 5'h01,
    ST_BOOT = 5'h02,
    ST_SW_STBY = 5'h04,
    ST_MEAS = 5'h08,
    ST_WAIT = 5'h10
  } pwr_state_e;

  typedef enum logic [3:0] {
    LP_IDLE = 4'h1,
    LP_ADDR = 4'h2,
    LP_INDEX = 4'h4,
    LP_DATA = 4'h8
  } link_phase_e;

endpackage

// ### rtl/tof_i2c_link.sv
`timescale 1ns/1ps
`default_nettype none

module tof_i2c_link
  import tof_pkg::*;
(
  // Reset, awake level from core
  input wire logic reset,
  input wire logic awake,
  // Bus pins
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Write event toward core
  output logic wr_tgl,
  output logic [7:0] wr_index,
  output logic [7:0] wr_data
);

  logic start_tgl_reg;
  logic start_seen_reg;
  logic awake_meta_reg;
  logic awake_sync_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic ack_req_reg;
  logic [7:0] idx_reg;
  link_phase_e phase_reg;
  logic [7:0] byte_in;
  logic new_frame;

  assign byte_in = {shift_reg, sda_i};
  assign new_frame = start_tgl_reg != start_seen_reg;

  // Start: data falls while clock high; toggle survives a stopped clock
  always_ff @(negedge sda_i or posedge reset) begin
    if (reset) begin
      start_tgl_reg <= 1'b0;
    end else if (scl) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  // Awake level; a frame's address bits give the edges it needs
  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      awake_meta_reg <= 1'b0;
      awake_sync_reg <= 1'b0;
    end else begin
      awake_meta_reg <= awake;
      awake_sync_reg <= awake_meta_reg;
    end
  end

  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      start_seen_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      ack_req_reg <= 1'b0;
      idx_reg <= 8'h00;
      phase_reg <= LP_IDLE;
      wr_tgl <= 1'b0;
      wr_index <= 8'h00;
      wr_data <= 8'h00;
    end else if (new_frame) begin
      start_seen_reg <= start_tgl_reg;
      bit_cnt_reg <= 4'h1;
      shift_reg <= {6'h00, sda_i};
      ack_req_reg <= 1'b0;
      phase_reg <= LP_ADDR;
    end else if (bit_cnt_reg == ACK_BIT) begin
      bit_cnt_reg <= 4'h0;
      ack_req_reg <= 1'b0;
    end else if (bit_cnt_reg == LAST_DATA_BIT) begin
      bit_cnt_reg <= ACK_BIT;
      unique case (phase_reg)
        LP_ADDR: begin
          ack_req_reg <= (byte_in == ADDR_WRITE) && awake_sync_reg;
          phase_reg <= ((byte_in == ADDR_WRITE) && awake_sync_reg) ? LP_INDEX : LP_IDLE;
        end
        LP_INDEX: begin
          ack_req_reg <= 1'b1;
          idx_reg <= byte_in;
          phase_reg <= LP_DATA;
        end
        LP_DATA: begin
          // Index steps on for sequential writes
          ack_req_reg <= 1'b1;
          wr_index <= idx_reg;
          wr_data <= byte_in;
          wr_tgl <= ~wr_tgl;
          idx_reg <= idx_reg + 8'h01;
        end
        LP_IDLE: begin
          ack_req_reg <= 1'b0;
        end
      endcase
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= {shift_reg[5:0], sda_i};
    end
  end

  // Acknowledge driven low across the ninth clock
  always_ff @(negedge scl or posedge reset) begin
    if (reset) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      sda_oe <= ack_req_reg && (bit_cnt_reg == ACK_BIT) && awake_sync_reg;
      sda_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### rtl/tof_ranging_power_mode_control.sv
// What this block does
// - The shutdown input is active low: low holds the sensor shut down, high lets it run.
// - Interrupts leave on their own pin, which only ever pulls low and relies on a pull-up for high.
// - Control arrives over a two-wire bus of up to 400 kHz, and the device answers address byte 0x52.
// - Hardware standby is entered by the shutdown input or by reset, and the bus stays silent in it.
// - A spad bias voltage setting and a phase calibration value from temperature calibration are applied.
// - Exactly three ranging modes exist: single, continuous and timed continuous.
// - Single mode makes one measurement per start and then returns to software standby by itself.
// - Continuous mode starts each measurement right after the last and finishes it on stop.
// - In timed mode a stop during the wait ends at once, a stop during a measurement lets it finish.
// - With interrupts enabled, each new result pulls the interrupt pin.
// - Shutdown held low means hardware standby whatever else is happening.
`timescale 1ns/1ps
`default_nettype none

module tof_ranging_power_mode_control
  import tof_pkg::*;
#(
  parameter int BOOT_CYC = BOOT_CYCLES,
  parameter int MEAS_CYC = MEAS_CYCLES,
  parameter int MS_CYC = MS_CYCLES
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Shutdown pin
  input wire logic shutdown_n,
  // Serial link
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Interrupt pin, open drain
  output logic interrupt_out_o,
  output logic interrupt_out_oe,
  // Sensitivity settings to the ranging core
  output logic [7:0] spad_bias_voltage_setting,
  output logic [7:0] phase_cal_value,
  // Status
  output logic hw_standby,
  output logic sw_standby,
  output logic measuring,
  output logic result_ready
);

  logic shut_meta_reg;
  logic shut_sync_reg;
  logic wr_meta_reg;
  logic wr_sync_reg;
  logic wr_seen_reg;
  logic link_tgl;
  logic [7:0] link_index;
  logic [7:0] link_data;
  logic awake_reg;
  logic wr_evt;
  logic start_req;
  logic stop_req;
  logic irq_clr_req;
  pwr_state_e state_reg;
  pwr_state_e state_next;
  range_mode_e mode_reg;
  logic irq_en_reg;
  logic [7:0] inter_meas_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic stop_pend_reg;
  logic meas_end;
  logic irq_pend_reg;

  tof_i2c_link u_link (
    .reset(reset),
    .awake(awake_reg),
    .scl(scl),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wr_tgl(link_tgl),
    .wr_index(link_index),
    .wr_data(link_data)
  );

  // Pin and link toggle synchronisers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shut_meta_reg <= 1'b0;
      shut_sync_reg <= 1'b0;
      wr_meta_reg <= 1'b0;
      wr_sync_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
    end else begin
      shut_meta_reg <= shutdown_n;
      shut_sync_reg <= shut_meta_reg;
      wr_meta_reg <= link_tgl;
      wr_sync_reg <= wr_meta_reg;
      wr_seen_reg <= wr_sync_reg;
    end
  end

  // Index and data held stable for a whole byte time after the toggle
  assign wr_evt = (wr_sync_reg != wr_seen_reg) && (state_reg != ST_HW_STBY);
  assign start_req = wr_evt && (link_index == IDX_CTRL) && link_data[CTRL_START_BIT];
  assign stop_req = wr_evt && (link_index == IDX_CTRL) && link_data[CTRL_STOP_BIT];
  assign irq_clr_req = wr_evt && (link_index == IDX_CTRL) && link_data[CTRL_IRQ_CLR_BIT];
  assign meas_end = (state_reg == ST_MEAS) && (cnt_reg == '0);

  // Configuration writes; shutdown wipes them like a hard reset
  always_ff @(posedge core_clk) begin
    if (reset || !shut_sync_reg) begin
      mode_reg <= MODE_SINGLE;
      irq_en_reg <= IRQ_EN_RST;
      inter_meas_reg <= INTER_MEAS_RST;
      spad_bias_voltage_setting <= SPAD_BIAS_RST;
      phase_cal_value <= PHASE_CAL_RST;
    end else if (wr_evt) begin
      unique case (link_index)
        IDX_MODE: begin
          // Only three codes, and only between runs
          if (state_reg == ST_SW_STBY && link_data[1:0] != 2'h3) begin
            mode_reg <= range_mode_e'(link_data[1:0]);
          end
        end
        IDX_IRQ_EN: begin
          irq_en_reg <= link_data[0];
        end
        IDX_SPAD_BIAS: begin
          spad_bias_voltage_setting <= link_data;
        end
        IDX_PHASE_CAL: begin
          phase_cal_value <= link_data;
        end
        IDX_INTER_MEAS: begin
          inter_meas_reg <= link_data;
        end
        default: begin
          mode_reg <= mode_reg;
        end
      endcase
    end
  end

  // Power and ranging sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg == '0) ? cnt_reg : cnt_reg - CNT_W'(1);
    unique case (state_reg)
      ST_HW_STBY: begin
        state_next = ST_BOOT;
        cnt_next = CNT_W'(BOOT_CYC - 1);
      end
      ST_BOOT: begin
        if (cnt_reg == '0) begin
          state_next = ST_SW_STBY;
        end
      end
      ST_SW_STBY: begin
        if (start_req) begin
          state_next = ST_MEAS;
          cnt_next = CNT_W'(MEAS_CYC - 1);
        end
      end
      ST_MEAS: begin
        if (meas_end) begin
          // Single ends by itself; stop lets the run finish
          if (mode_reg == MODE_SINGLE || stop_pend_reg || stop_req) begin
            state_next = ST_SW_STBY;
          end else if (mode_reg == MODE_CONT) begin
            state_next = ST_MEAS;
            cnt_next = CNT_W'(MEAS_CYC - 1);
          end else begin
            state_next = ST_WAIT;
            cnt_next = CNT_W'(inter_meas_reg * MS_CYC);
          end
        end
      end
      ST_WAIT: begin
        // Stop in the wait ends at once
        if (stop_req) begin
          state_next = ST_SW_STBY;
        end else if (cnt_reg == '0) begin
          state_next = ST_MEAS;
          cnt_next = CNT_W'(MEAS_CYC - 1);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset || !shut_sync_reg) begin
      state_reg <= ST_HW_STBY;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Stop during a measurement waits for its end
  always_ff @(posedge core_clk) begin
    if (reset || !shut_sync_reg || state_next != ST_MEAS) begin
      stop_pend_reg <= 1'b0;
    end else if (stop_req) begin
      stop_pend_reg <= 1'b1;
    end
  end

  // Bus answers only once out of hardware standby
  always_ff @(posedge core_clk) begin
    if (reset || !shut_sync_reg) begin
      awake_reg <= 1'b0;
    end else begin
      awake_reg <= 1'b1;
    end
  end

  // Result raises interrupt; set beats clear
  always_ff @(posedge core_clk) begin
    if (reset || !shut_sync_reg) begin
      irq_pend_reg <= 1'b0;
    end else if (meas_end && irq_en_reg) begin
      irq_pend_reg <= 1'b1;
    end else if (irq_clr_req) begin
      irq_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      interrupt_out_o <= 1'b0;
      interrupt_out_oe <= 1'b0;
    end else begin
      interrupt_out_o <= 1'b0;
      interrupt_out_oe <= irq_pend_reg;
    end
  end

  // Status flags, one cycle behind the state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hw_standby <= 1'b1;
      sw_standby <= 1'b0;
      measuring <= 1'b0;
      result_ready <= 1'b0;
    end else begin
      hw_standby <= state_reg == ST_HW_STBY;
      sw_standby <= state_reg == ST_SW_STBY;
      measuring <= state_reg == ST_MEAS;
      result_ready <= meas_end && shut_sync_reg;
    end
  end

endmodule

`default_nettype wire

// ### tb/tof_ranging_props.sv
`timescale 1ns/1ps
`default_nettype none

module tof_ranging_props #(
  parameter int BOOT_CYC = 20,
  parameter int MEAS_CYC = 50,
  parameter int MS_CYC = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pins
  input wire logic shutdown_n,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic interrupt_out_o,
  input wire logic interrupt_out_oe,
  // Status
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic measuring,
  input wire logic result_ready
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_irq_open_drain: assert property (interrupt_out_o == 1'b0) else $error("irq pin driven high");
  a_sda_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
  // Two sync flops, state, then the status register: flag shows on the fifth edge
  a_shut_forces_hw: assert property (!shutdown_n [*5] |-> hw_standby) else $error("no hw standby");
  a_release_runs: assert property (shutdown_n [*8] |=> !hw_standby) else $error("stuck in hw standby");
  a_hw_bus_quiet: assert property (hw_standby [*4] |-> !sda_oe) else $error("ack in hw standby");
  a_hw_all_idle: assert property (hw_standby |-> !(sw_standby || measuring || interrupt_out_oe))
    else $error("activity in hw standby");
  a_boot_takes_time: assert property ($fell(hw_standby) |-> !sw_standby [*8]) else $error("boot skipped");
  a_result_after_meas: assert property (result_ready |-> $past(measuring) ##1 !result_ready)
    else $error("result without measurement");
  a_irq_after_result: assert property ($rose(interrupt_out_oe) |-> $past(result_ready) || $past(result_ready, 2))
    else $error("irq without result");
  a_meas_not_cut: assert property ($fell(measuring) |-> result_ready || $past(result_ready) || hw_standby)
    else $error("measurement cut short");
  a_one_state: assert property (!(sw_standby && measuring)) else $error("two states at once");

  cover property (result_ready);
  cover property ($fell(hw_standby));
  cover property (sda_oe);
endmodule

bind tof_ranging_power_mode_control tof_ranging_props #(.BOOT_CYC(BOOT_CYC), .MEAS_CYC(MEAS_CYC),
  .MS_CYC(MS_CYC)) u_props (.core_clk(core_clk), .reset(reset), .shutdown_n(shutdown_n), .sda_o(sda_o),
  .sda_oe(sda_oe), .interrupt_out_o(interrupt_out_o), .interrupt_out_oe(interrupt_out_oe),
  .hw_standby(hw_standby), .sw_standby(sw_standby), .measuring(measuring), .result_ready(result_ready));

`default_nettype wire

// ### tb/tof_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module tof_host_model (
  // Bus pins, host side
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam time HALF = 24;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // MSB first, ack read at ninth rise
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #HALF scl = 1'b0;
      sda_pull = ~b[i];
      #HALF scl = 1'b1;
    end
    #HALF scl = 1'b0;
    sda_pull = 1'b0;
    #HALF scl = 1'b1;
    ack = ~sda;
  endtask
  // Clock stands high between frames
  task automatic frame(input logic [7:0] addr, input logic [7:0] idx, input logic [7:0] dat, output logic acked);
    logic a0, a1, a2;
    #HALF sda_pull = 1'b1;
    put_byte(addr, a0);
    put_byte(idx, a1);
    put_byte(dat, a2);
    #HALF scl = 1'b0;
    sda_pull = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_pull = 1'b0;
    acked = a0 & a1 & a2;
  endtask
endmodule

`default_nettype wire

// ### tb/tof_ranging_power_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tof_ranging_power_mode_control_bench;
  import tof_pkg::*;
  localparam int BOOT = 20;
  localparam int MEAS = 50;
  localparam int MS = 10;
  logic core_clk = 1'b0;
  logic reset = 1'b0;
  logic shutdown_n = 1'b1;
  wire logic scl, sda_pull, sda;
  logic sda_o, sda_oe, irq_o, irq_oe, hw, sw, meas, rr, ok, hit;
  logic [7:0] bias, phase, b, p, w;
  integer seed = 32'hdb4b;
  int n_fail = 0;
  int cmp_count = 0;

  always #50 core_clk = ~core_clk;
  assign sda = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

  tof_ranging_power_mode_control #(.BOOT_CYC(BOOT), .MEAS_CYC(MEAS), .MS_CYC(MS)) u_dut (
    .core_clk(core_clk), .reset(reset), .shutdown_n(shutdown_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .interrupt_out_o(irq_o), .interrupt_out_oe(irq_oe), .spad_bias_voltage_setting(bias),
    .phase_cal_value(phase), .hw_standby(hw), .sw_standby(sw), .measuring(meas), .result_ready(rr));
  tof_host_model u_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait: 0 result, 1 sw standby, 2 measuring
  task automatic wait_on(input int sel, input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      cyc(1);
      hit = (sel == 0) ? rr : (sel == 1) ? sw : meas;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    u_host.frame(8'h52, idx, dat, ok);
    check(ok, 1'b1);
    cyc(6);
  endtask

  initial begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end

  initial begin
    // A real rising edge, or the link flops never see their reset
    reset <= 1'b1;
    cyc(10);
    check(hw, 1'b1);
    @(posedge core_clk);
    reset <= 1'b0;
    wait_on(1, BOOT + 10);
    check(hit, 1'b1);
    u_host.frame(8'h53, IDX_CTRL, 8'h01, ok);
    check(ok, 1'b0);
    u_host.frame(8'h50, IDX_CTRL, 8'h01, ok);
    check(ok, 1'b0);
    cyc(6);
    check(meas, 1'b0);
    // Second pass stands for a recalibration
    for (int k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      p = 8'($random(seed));
      wr(IDX_SPAD_BIAS, b);
      wr(IDX_PHASE_CAL, p);
      check(bias, b);
      check(phase, p);
    end
    wr(IDX_IRQ_EN, 8'h01);
    wr(IDX_MODE, MODE_SINGLE);
    // Code 3 refused, so the run below must stay single
    wr(IDX_MODE, 8'h03);
    wr(IDX_CTRL, 8'h01);
    check(meas, 1'b1);
    wait_on(0, MEAS);
    check(hit, 1'b1);
    cyc(3);
    check(sw, 1'b1);
    check(irq_oe, 1'b1);
    cyc(MEAS);
    check(meas, 1'b0);
    wr(IDX_CTRL, 8'h04);
    check(irq_oe, 1'b0);
    wr(IDX_MODE, MODE_CONT);
    wr(IDX_CTRL, 8'h01);
    wait_on(0, MEAS);
    check(hit, 1'b1);
    cyc(2);
    check(meas, 1'b1);
    wr(IDX_CTRL, 8'h02);
    check(meas, 1'b1);
    wait_on(0, MEAS);
    cyc(3);
    check(sw, 1'b1);
    // Wait kept longer than a stop frame so the stop lands inside it
    w = 8'd5 + 8'({$random(seed)} % 4);
    wr(IDX_INTER_MEAS, w);
    wr(IDX_MODE, MODE_TIMED);
    wr(IDX_CTRL, 8'h01);
    wait_on(0, MEAS);
    check(hit, 1'b1);
    cyc(w * MS - 4);
    check(meas, 1'b0);
    wait_on(2, 8);
    check(hit, 1'b1);
    wr(IDX_CTRL, 8'h02);
    check(meas, 1'b1);
    wait_on(0, MEAS);
    cyc(3);
    check(sw, 1'b1);
    wr(IDX_CTRL, 8'h01);
    wait_on(0, MEAS);
    wr(IDX_CTRL, 8'h02);
    check(sw, 1'b1);
    cyc(w * MS);
    check(meas, 1'b0);
    @(posedge core_clk);
    // Pin always at a defined level
    shutdown_n <= 1'b0;
    cyc(5);
    check(hw, 1'b1);
    check(bias, 8'h00);
    check(irq_oe, 1'b0);
    u_host.frame(8'h52, IDX_CTRL, 8'h01, ok);
    check(ok, 1'b0);
    @(posedge core_clk);
    shutdown_n <= 1'b1;
    wait_on(1, BOOT + 10);
    check(hit, 1'b1);
    check(phase, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
